// ===== logic/bwhp_dev.sv
// Device end of the byte-wide host port: control, address and data
// access into core memory, ready handshake, interrupt, pin I/O mode.
// Assumes an external host on the pins and single-cycle core memory.
//
// Behaviour
// - Combined strobe is OR of three selects
// - Ready high whenever chip select high
// - Ready low after strobe rise needing work
// - Memory busy longer while DMA active
// - Interrupt-bit control writes pulse ready low
// - Other control writes leave ready high
// - Ready rises on core clock rising edge
// - Interrupt pin changes on core clock rise
// - Read drives bus strobe low, releases after
// - Two byte phases; first byte later if busy
// - Write byte captured at strobe rise
// - Half select latched at address strobe fall, else at strobe fall
// - Address strobe low precedes combined strobe
// - Pin inputs sampled on core clock rise
// - Pin outputs updated after core clock rise
// - Pin I/O mode replaces host transfers
`timescale 1ns/1ps
`default_nettype none
module bwhp_dev
  import bwhp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  bwhp_if.dev              pins,
  input  wire logic        dma_active,   // Core DMA is running
  input  wire logic        gpio_mode,    // Data pins as plain I/O
  input  wire logic [7:0]  gpio_dir,     // High: pin is output
  input  wire logic [7:0]  gpio_drive,   // Output levels
  input  wire logic        host_int_set, // Core raises host interrupt
  input  wire logic [15:0] mem_rdata,    // Read data, cycle after req
  output logic [7:0]       gpio_in_q,
  output logic             mem_req_q,
  output logic             mem_we_q,
  output logic [15:0]      mem_addr_q,
  output logic [15:0]      mem_wdata_q,
  output logic             core_int_q    // Host-to-core pulse
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Order: cs, ds1, ds2, as, type0, type1, rw, half, bus[7:0]
  logic [15:0] s1_q, s2_q, s3_q; // Three-flop chain
  logic [15:0] f_q, f_d;         // Filtered pin levels
  always_comb begin
    for (int i = 0; i < 16; i++)
      f_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : f_q[i];
  end
  always_ff @(posedge ref_clk) begin
    s1_q <= {pins.host_chip_select_n, pins.host_data_strobe_one_n,
             pins.host_data_strobe_two_n, pins.addr_strobe_n,
             pins.access_type_select_0, pins.access_type_select_1,
             pins.read_write_select, pins.byte_half_select,
             pins.host_byte_bus};
    s2_q <= s1_q;
    s3_q <= s2_q;
    f_q  <= srst ? 16'hf000 : f_d;
  end

  logic       cs_f, ds_f, as_f, rw_f, half_f;
  logic [1:0] type_f;
  logic [7:0] bus_f;
  assign cs_f   = f_q[15];
  assign ds_f   = f_q[15] | f_q[14] | f_q[13];
  assign as_f   = f_q[12];
  assign type_f = {f_q[10], f_q[11]};
  assign rw_f   = f_q[9];
  assign half_f = f_q[8];
  assign bus_f  = f_q[7:0];

  // ************************************************************
  // Access state machine
  // ************************************************************
  typedef enum {D_IDLE, D_LOW, D_BUSY} bwhp_dst_t;
  bwhp_dst_t   st_q, st_d;       // Access phase
  logic        cclk_q, cclk_d;   // Core clock, ref_clk / 2
  logic        ds_p_q, as_p_q;   // Previous strobe levels
  logic [4:0]  cnt_q, cnt_d;     // Busy countdown
  logic [4:0]  hi_q, hi_d;       // Strobe high time, saturating
  logic [4:0]  dly_q, dly_d;     // First byte hold-off
  logic [1:0]  lt_q, lt_d;       // Latched type
  logic        lrw_q, lrw_d;     // Latched direction
  logic        lh_q, lh_d;       // Latched half
  logic [7:0]  ctrl_q, ctrl_d;   // Control register
  logic [15:0] addr_q, addr_d;   // Address register
  logic [7:0]  hold_q, hold_d;   // First write byte
  logic [15:0] rdw_q, rdw_d;     // Prefetched read word
  logic        pend_q, pend_d;   // Read data due next cycle
  logic        host_interrupt_out_q, host_interrupt_out_d;   // Host interrupt flag
  logic        hpin_q, hpin_d;   // Interrupt pin, low active
  logic        rdy_q, rdy_d;     // Ready pin
  logic [7:0]  oe_q, oe_d;       // Bus enables
  logic [7:0]  out_q, out_d;     // Bus value
  logic [7:0]  gin_d;
  logic        req_d, we_d, cint_d;
  logic [15:0] maddr_d, mwd_d;
  logic        cclk_rise;        // Core clock rises at this edge
  logic        ds_fall, ds_rise, as_fall;
  logic [1:0]  ct;               // Type seen at strobe fall
  logic        ch, crw;
  logic [4:0]  base;
  logic [7:0]  rbyte;

  assign cclk_rise = ~cclk_q;
  assign ds_fall   = ds_p_q & ~ds_f;
  assign ds_rise   = ~ds_p_q & ds_f;
  assign as_fall   = as_p_q & ~as_f;

  // Byte the host sees for the latched access
  function automatic logic [7:0] rd_sel(input logic [1:0]  t,
                                        input logic        h,
                                        input logic [7:0]  c,
                                        input logic [15:0] a,
                                        input logic [15:0] w);
    case (t)
      SEL_CTRL: return c;
      SEL_ADDR: return bwhp_pick(a, h);
      default:  return bwhp_pick(w, h);
    endcase
  endfunction

  // Next values of the access logic
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; dly_d = dly_q;
    lt_d = lt_q; lrw_d = lrw_q; lh_d = lh_q;
    ctrl_d = ctrl_q; addr_d = addr_q; hold_d = hold_q;
    rdw_d = rdw_q; oe_d = oe_q; out_d = out_q;
    req_d = 1'b0; we_d = 1'b0; cint_d = 1'b0;
    maddr_d = mem_addr_q; mwd_d = mem_wdata_q;
    gin_d = gpio_in_q; hpin_d = hpin_q;
    cclk_d = ~cclk_q;
    hi_d = (ds_f && hi_q != 5'h1f) ? hi_q + 5'h01 : hi_q;
    base = dma_active ? 5'(DMA_CYC) : 5'(IDLE_CYC);
    // Address strobe in use: it latches, else the strobe does
    if (as_fall) begin
      lt_d = type_f; lrw_d = rw_f; lh_d = half_f;
    end
    ct  = as_f ? type_f : lt_q;
    ch  = as_f ? half_f : lh_q;
    crw = as_f ? rw_f : lrw_q;
    rbyte = rd_sel(lt_q, lh_q, ctrl_q, addr_q, rdw_q);
    // Prefetched word lands one cycle after the request
    pend_d = 1'b0;
    if (pend_q) rdw_d = mem_rdata;
    // Set beats the software clear in the same cycle
    host_interrupt_out_d = host_interrupt_out_q;
    case (st_q)
      D_IDLE: begin
        oe_d = 8'h00;
        if (gpio_mode) begin
          // Pins follow the core clock in I/O mode
          oe_d = gpio_dir;
          if (cclk_rise) begin
            out_d = gpio_drive;
            gin_d = bus_f;
          end
        end else if (ds_fall) begin
          lt_d = ct; lh_d = ch; lrw_d = crw;
          hi_d = 5'h00;
          st_d = D_LOW;
          dly_d = 5'h00;
          // Short strobe-high time delays the first read byte
          if (crw && !ch && ct[0] && hi_q < base)
            dly_d = base - hi_q;
          if (crw) oe_d = 8'hff;
        end
      end
      D_LOW: begin
        if (lrw_q) begin
          oe_d = 8'hff;
          if (dly_q != 5'h00) dly_d = dly_q - 5'h01;
          else out_d = rbyte;
        end
        if (ds_rise) begin
          oe_d = 8'h00;
          st_d = D_IDLE;
          cnt_d = base;
          case (lt_q)
            SEL_CTRL: if (!lrw_q) begin
              // Interrupt bits strobe, never stay set
              ctrl_d = bus_f;
              ctrl_d[CORE_INT_BIT] = 1'b0;
              ctrl_d[HOST_INT_BIT] = 1'b0;
              cint_d = bus_f[CORE_INT_BIT];
              if (bus_f[HOST_INT_BIT]) host_interrupt_out_d = 1'b0;
              if (bus_f[CORE_INT_BIT] || bus_f[HOST_INT_BIT]) begin
                cnt_d = 5'(CTRL_CYC);
                st_d = D_BUSY;
              end
            end
            SEL_ADDR: if (!lrw_q) begin
              if (!lh_q) addr_d[15:8] = bus_f;
              else begin
                addr_d[7:0] = bus_f;
                maddr_d = {addr_q[15:8], bus_f};
                req_d = 1'b1; pend_d = 1'b1;
                st_d = D_BUSY;
              end
            end
            default: begin
              if (!lrw_q && !lh_q) hold_d = bus_f;
              else if (!lrw_q) begin
                maddr_d = addr_q; mwd_d = {hold_q, bus_f};
                req_d = 1'b1; we_d = 1'b1;
                if (lt_q == SEL_DATA_INC) addr_d = addr_q + 16'h0001;
                st_d = D_BUSY;
              end else if (lh_q) begin
                // Next word fetched while the host waits
                if (lt_q == SEL_DATA_INC) addr_d = addr_q + 16'h0001;
                maddr_d = addr_d;
                req_d = 1'b1; pend_d = 1'b1;
                st_d = D_BUSY;
              end
            end
          endcase
        end
      end
      D_BUSY: begin
        // Strobes during busy are ignored
        if (cnt_q != 5'h00) cnt_d = cnt_q - 5'h01;
        else if (cclk_rise) st_d = D_IDLE;
      end
      default: st_d = D_IDLE;
    endcase
    if (host_int_set) host_interrupt_out_d = 1'b1;
    if (cclk_rise) hpin_d = ~host_interrupt_out_q;
    rdy_d = cs_f | (st_d != D_BUSY);
  end

  // Access registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= D_IDLE; cclk_q <= 1'b0; ds_p_q <= 1'b1; as_p_q <= 1'b1;
      cnt_q <= 5'h00; hi_q <= 5'h1f; dly_q <= 5'h00;
      lt_q <= SEL_CTRL; lrw_q <= 1'b0; lh_q <= 1'b0;
      ctrl_q <= CTRL_RST; addr_q <= ADDR_RST; hold_q <= 8'h00;
      rdw_q <= 16'h0000; pend_q <= 1'b0; host_interrupt_out_q <= 1'b0;
      hpin_q <= 1'b1; rdy_q <= 1'b1; oe_q <= 8'h00; out_q <= 8'h00;
      gpio_in_q <= 8'h00; mem_req_q <= 1'b0; mem_we_q <= 1'b0;
      mem_addr_q <= ADDR_RST; mem_wdata_q <= 16'h0000;
      core_int_q <= 1'b0;
    end else begin
      st_q <= st_d; cclk_q <= cclk_d; ds_p_q <= ds_f; as_p_q <= as_f;
      cnt_q <= cnt_d; hi_q <= hi_d; dly_q <= dly_d;
      lt_q <= lt_d; lrw_q <= lrw_d; lh_q <= lh_d;
      ctrl_q <= ctrl_d; addr_q <= addr_d; hold_q <= hold_d;
      rdw_q <= rdw_d; pend_q <= pend_d; host_interrupt_out_q <= host_interrupt_out_d;
      hpin_q <= hpin_d; rdy_q <= rdy_d; oe_q <= oe_d; out_q <= out_d;
      gpio_in_q <= gin_d; mem_req_q <= req_d; mem_we_q <= we_d;
      mem_addr_q <= maddr_d; mem_wdata_q <= mwd_d;
      core_int_q <= cint_d;
    end
  end

  // ************************************************************
  // Pin drivers, all from flops
  // ************************************************************
  assign pins.dev_byte_out         = out_q;
  assign pins.dev_byte_oe          = oe_q;
  assign pins.host_ready_out       = rdy_q;
  assign pins.host_interrupt_out_n = hpin_q;
  assign pins.core_clock_out       = cclk_q;
endmodule
`default_nettype wire

// ===== logic/bwhp_pkg.sv
// Constants shared by both ends of the byte-wide host port.
// Assumes one 50 MHz reference clock on both ends.
`default_nettype none
package bwhp_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_NS   = 20;   // Reference clock period
  localparam int P_NS     = 10;   // Half processor period P
  localparam int DMA_P    = 18;   // Busy time, DMA active, in P
  localparam int IDLE_P   = 10;   // Busy time, DMA idle, in P
  localparam int CTRL_P   = 6;    // Busy time, control write, in P
  // Longest times round down, never below one cycle
  localparam int DMA_CYC  = (DMA_P * P_NS / CLK_NS > 0) ?
                            DMA_P * P_NS / CLK_NS : 1;
  localparam int IDLE_CYC = (IDLE_P * P_NS / CLK_NS > 0) ?
                            IDLE_P * P_NS / CLK_NS : 1;
  localparam int CTRL_CYC = (CTRL_P * P_NS / CLK_NS > 0) ?
                            CTRL_P * P_NS / CLK_NS : 1;
  // ************************************************************
  // Access types and control fields
  // ************************************************************
  localparam logic [1:0] SEL_CTRL     = 2'h0; // Control register
  localparam logic [1:0] SEL_DATA_INC = 2'h1; // Data, auto-increment
  localparam logic [1:0] SEL_ADDR     = 2'h2; // Address register
  localparam logic [1:0] SEL_DATA     = 2'h3; // Data, fixed address
  localparam int CORE_INT_BIT = 1;            // Host-to-core interrupt
  localparam int HOST_INT_BIT = 2;            // Host interrupt clear
  localparam logic [7:0]  CTRL_RST = 8'h00;   // Control reset value
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0]  IDLE_BUS = 8'hff;   // Undriven bus level

  // First byte is the high byte of a word
  function automatic logic [7:0] bwhp_pick(input logic [15:0] w,
                                           input logic        second);
    return second ? w[7:0] : w[15:8];
  endfunction
endpackage
`default_nettype wire

// ===== logic/bwhp_if.sv
// Pin bundle between the external host and the device port.
// Assumes both ends drive through enables; level resolved here.
`timescale 1ns/1ps
`default_nettype none
interface bwhp_if;
  import bwhp_pkg::*;
  logic       host_chip_select_n;     // Chip select, low active
  logic       host_data_strobe_one_n; // Data strobe one
  logic       host_data_strobe_two_n; // Data strobe two
  logic       addr_strobe_n;          // Optional address strobe
  logic       access_type_select_0;   // Access type, bit 0
  logic       access_type_select_1;   // Access type, bit 1
  logic       read_write_select;      // High reads
  logic       byte_half_select;       // High for second byte
  logic [7:0] host_byte_out;          // Host drive value
  logic       host_byte_oe;           // Host drives bus
  logic [7:0] dev_byte_out;           // Device drive value
  logic [7:0] dev_byte_oe;            // Device drives bus, per pin
  logic       host_ready_out;         // Device ready
  logic       host_interrupt_out_n;   // Device interrupt, low active
  logic       core_clock_out;         // Device core clock
  logic [7:0] host_byte_bus;          // Resolved bus level

  // Per pin: device, then host, else pulled high
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      host_byte_bus[i] = dev_byte_oe[i] ? dev_byte_out[i] :
                         host_byte_oe   ? host_byte_out[i] : IDLE_BUS[i];
    end
  end

  modport dev (
    input  host_chip_select_n, host_data_strobe_one_n,
    input  host_data_strobe_two_n, addr_strobe_n,
    input  access_type_select_0, access_type_select_1,
    input  read_write_select, byte_half_select, host_byte_bus,
    output dev_byte_out, dev_byte_oe, host_ready_out,
    output host_interrupt_out_n, core_clock_out
  );
  modport host (
    output host_chip_select_n, host_data_strobe_one_n,
    output host_data_strobe_two_n, addr_strobe_n,
    output access_type_select_0, access_type_select_1,
    output read_write_select, byte_half_select,
    output host_byte_out, host_byte_oe,
    input  host_byte_bus, host_ready_out, host_interrupt_out_n,
    input  core_clock_out
  );
endinterface
`default_nettype wire

// ===== logic/bwhp_host.sv
// External host end: turns word commands into two byte phases.
// Assumes the device end across the pins, on its own timing.
`timescale 1ns/1ps
`default_nettype none
module bwhp_host
  import bwhp_pkg::*;
#(
  parameter int SETUP_CYC = 2,   // Select setup before strobe
  parameter int LOW_CYC   = 20,  // Strobe low time
  parameter int GAP_CYC   = 10   // Strobe high before ready poll
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  bwhp_if.host             pins,
  input  wire logic        cmd_valid,
  input  wire logic [1:0]  cmd_type,
  input  wire logic        cmd_rw,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        use_addr_strobe,
  output logic             cmd_ready_q,
  output logic             rsp_valid_q,
  output logic [15:0]      rsp_rdata_q
);
  // Ready must have time to fall and pass both synchronisers;
  // the six-bit phase timer holds at most 63
  if (LOW_CYC < 16 || GAP_CYC < 8 || SETUP_CYC < 1 ||
      LOW_CYC > 63 || GAP_CYC > 63 || SETUP_CYC > 63) begin : g_bad_cyc
    $error("bwhp_host: timing parameters out of range");
  end

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [8:0] s1_q, s2_q, s3_q, f_q, f_d; // Ready and bus
  always_comb begin
    for (int i = 0; i < 9; i++)
      f_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : f_q[i];
  end
  always_ff @(posedge ref_clk) begin
    s1_q <= {pins.host_ready_out, pins.host_byte_bus};
    s2_q <= s1_q;
    s3_q <= s2_q;
    f_q  <= srst ? 9'h1ff : f_d;
  end

  // ************************************************************
  // Phase sequencer
  // ************************************************************
  typedef enum {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_WAIT} bwhp_hst_t;
  bwhp_hst_t   st_q, st_d;     // Phase state
  logic [5:0]  cnt_q, cnt_d;   // Phase timer
  logic        half_q, half_d; // Current byte half
  logic [1:0]  type_q, type_d; // Latched command
  logic        rw_q, rw_d;
  logic        has_q, has_d;   // Address strobe in use
  logic [15:0] wd_q, wd_d;     // Write word
  logic [15:0] rd_q, rd_d;     // Read word
  logic        cs_q, cs_d, ds_q, ds_d, as_q, as_d, oe_q, oe_d;
  logic        rdy_q, rdy_d, vld_q, vld_d;

  // Next state of the sequencer
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; half_d = half_q; type_d = type_q;
    rw_d = rw_q; has_d = has_q; wd_d = wd_q; rd_d = rd_q;
    cs_d = cs_q; ds_d = ds_q; as_d = as_q; oe_d = oe_q;
    rdy_d = 1'b0; vld_d = 1'b0;
    case (st_q)
      H_IDLE: begin
        cs_d = 1'b1; as_d = 1'b1; rdy_d = 1'b1;
        if (cmd_valid && cmd_ready_q) begin
          type_d = cmd_type; rw_d = cmd_rw; wd_d = cmd_wdata;
          has_d = use_addr_strobe; half_d = 1'b0; rdy_d = 1'b0;
          cs_d = 1'b0; cnt_d = 6'(SETUP_CYC); st_d = H_SETUP;
        end
      end
      H_SETUP: begin
        // Half select stands before the strobe that latches it
        as_d = ~has_q;
        oe_d = ~rw_q;
        cnt_d = cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          ds_d = 1'b0; cnt_d = 6'(LOW_CYC); st_d = H_LOW;
        end
      end
      H_LOW: begin
        cnt_d = cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          // Read byte sampled just before strobe rise
          if (rw_q && !half_q) rd_d[15:8] = f_q[7:0];
          if (rw_q && half_q) rd_d[7:0] = f_q[7:0];
          ds_d = 1'b1; as_d = 1'b1;
          cnt_d = 6'(GAP_CYC); st_d = H_HIGH;
        end
      end
      H_HIGH: begin
        oe_d = 1'b0;
        cnt_d = cnt_q - 6'h01;
        if (cnt_q == 6'h01) st_d = H_WAIT;
      end
      H_WAIT: begin
        if (f_q[8]) begin
          if (!half_q) begin
            half_d = 1'b1; cnt_d = 6'(SETUP_CYC); st_d = H_SETUP;
          end else begin
            vld_d = rw_q; cs_d = 1'b1; st_d = H_IDLE;
          end
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= H_IDLE; cnt_q <= 6'h00; half_q <= 1'b0;
      type_q <= SEL_CTRL; rw_q <= 1'b0; has_q <= 1'b0;
      wd_q <= 16'h0000; rd_q <= 16'h0000;
      cs_q <= 1'b1; ds_q <= 1'b1; as_q <= 1'b1; oe_q <= 1'b0;
      rdy_q <= 1'b0; vld_q <= 1'b0;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; half_q <= half_d;
      type_q <= type_d; rw_q <= rw_d; has_q <= has_d;
      wd_q <= wd_d; rd_q <= rd_d;
      cs_q <= cs_d; ds_q <= ds_d; as_q <= as_d; oe_q <= oe_d;
      rdy_q <= rdy_d; vld_q <= vld_d;
    end
  end

  // Chip select and strobe two held low inside the command
  assign pins.host_chip_select_n     = cs_q;
  assign pins.host_data_strobe_one_n = ds_q;
  assign pins.host_data_strobe_two_n = cs_q;
  assign pins.addr_strobe_n          = as_q;
  assign pins.access_type_select_0   = type_q[0];
  assign pins.access_type_select_1   = type_q[1];
  assign pins.read_write_select      = rw_q;
  assign pins.byte_half_select       = half_q;
  assign pins.host_byte_out          = bwhp_pick(wd_q, half_q);
  assign pins.host_byte_oe           = oe_q;
  assign cmd_ready_q                 = rdy_q;
  assign rsp_valid_q                 = vld_q;
  assign rsp_rdata_q                 = rd_q;
endmodule
`default_nettype wire

// ===== bench/bwhp_assertions.sv
// Pin-level checker for the byte-wide host port.
// Assumes one clock domain; inputs are the pin bundle signals.
`timescale 1ns/1ps
`default_nettype none
module bwhp_assertions (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       host_chip_select_n,
  input wire logic       host_data_strobe_one_n,
  input wire logic       host_data_strobe_two_n,
  input wire logic       read_write_select,
  input wire logic [7:0] dev_byte_oe,
  input wire logic       host_ready_out,
  input wire logic       host_interrupt_out_n,
  input wire logic       core_clock_out
);
  // ****************************************
  // Pin relations
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Combined strobe; bit 0 only, upper pins may be plain outputs
  wire ds = host_chip_select_n | host_data_strobe_one_n
            | host_data_strobe_two_n;
  property p_cs; host_chip_select_n [*7] |-> host_ready_out; endproperty
  a_cs: assert property (p_cs)
    else $error("ready low while deselected");
  property p_rck;
    $rose(host_ready_out) && !host_chip_select_n |-> $rose(core_clock_out);
  endproperty
  a_rck: assert property (p_rck)
    else $error("ready rose off core clock");
  property p_irq; $changed(host_interrupt_out_n) |-> $rose(core_clock_out);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq moved off core clock");
  property p_fall; $fell(host_ready_out) |-> ds; endproperty
  a_fall: assert property (p_fall)
    else $error("ready fell with strobe low");
  property p_busy; $fell(host_ready_out) |-> ##[1:14] host_ready_out;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy too long");
  property p_drv; $rose(dev_byte_oe[0]) |-> read_write_select && !ds;
  endproperty
  a_drv: assert property (p_drv)
    else $error("bus driven outside read");
  property p_rel; $fell(dev_byte_oe[0]) |-> ds; endproperty
  a_rel: assert property (p_rel)
    else $error("bus released with strobe low");
  property p_wr; !read_write_select && !ds |-> !dev_byte_oe[0]; endproperty
  a_wr: assert property (p_wr)
    else $error("bus driven during write");
  c_busy: cover property ($fell(host_ready_out));
  c_read: cover property ($rose(dev_byte_oe[0]));
  c_irq: cover property ($fell(host_interrupt_out_n));
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Testbench: host end and device end joined by the pin bundle.
// Assumes a one-cycle core memory modelled here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bwhp_pkg::*;
  // ****************************************
  // Stimulus, memory model and checks
  // ****************************************
  logic        ref_clk, srst, cmd_valid, cmd_rw, use_as, dma_active;
  logic        gpio_mode, host_int_set, cmd_ready_q, rsp_valid_q;
  logic        mem_req_q, mem_we_q, core_int_q;
  logic [1:0]  cmd_type;
  logic [7:0]  gpio_dir, gpio_drive, gpio_in_q;
  logic [15:0] cmd_wdata, mem_rdata, rsp_rdata_q, mem_addr_q, mem_wdata_q;
  logic [15:0] got, mem [256];
  int          n_mismatch, checked, lo_run, lo_len, n_fall, n_cint, c0;
  int          len [2];
  bwhp_if bwhp_if_inst ();
  bwhp_host bwhp_host_inst (.ref_clk(ref_clk), .srst(srst),
    .pins(bwhp_if_inst), .cmd_valid(cmd_valid), .cmd_type(cmd_type),
    .cmd_rw(cmd_rw), .cmd_wdata(cmd_wdata), .use_addr_strobe(use_as),
    .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q),
    .rsp_rdata_q(rsp_rdata_q));
  bwhp_dev bwhp_dev_inst (.ref_clk(ref_clk), .srst(srst),
    .pins(bwhp_if_inst), .dma_active(dma_active), .gpio_mode(gpio_mode),
    .gpio_dir(gpio_dir), .gpio_drive(gpio_drive),
    .host_int_set(host_int_set), .mem_rdata(mem_rdata),
    .gpio_in_q(gpio_in_q), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .core_int_q(core_int_q));
  bwhp_assertions bwhp_assertions_inst (.ref_clk(ref_clk), .srst(srst),
    .host_chip_select_n(bwhp_if_inst.host_chip_select_n),
    .host_data_strobe_one_n(bwhp_if_inst.host_data_strobe_one_n),
    .host_data_strobe_two_n(bwhp_if_inst.host_data_strobe_two_n),
    .read_write_select(bwhp_if_inst.read_write_select),
    .dev_byte_oe(bwhp_if_inst.dev_byte_oe),
    .host_ready_out(bwhp_if_inst.host_ready_out),
    .host_interrupt_out_n(bwhp_if_inst.host_interrupt_out_n),
    .core_clock_out(bwhp_if_inst.core_clock_out));
  always #10 ref_clk = ~ref_clk;
  // Read data set at the falling edge, so the word of a request
  // stands on the bus at the very next rising edge
  always @(negedge ref_clk) mem_rdata <= mem[mem_addr_q[7:0]];
  // Writes land the edge after the request; busy run lengths kept
  always @(posedge ref_clk) begin
    if (mem_req_q && mem_we_q) mem[mem_addr_q[7:0]] <= mem_wdata_q;
    lo_run <= bwhp_if_inst.host_ready_out ? 0 : lo_run + 1;
    if (bwhp_if_inst.host_ready_out && lo_run != 0) lo_len <= lo_run;
    if (!bwhp_if_inst.host_ready_out && lo_run == 0) n_fall <= n_fall + 1;
    if (core_int_q) n_cint <= n_cint + 1;
    if (rsp_valid_q) got <= rsp_rdata_q;
  end
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Polled at the falling edge, where the host outputs are settled
  task automatic wait_ready();
    int k;
    for (k = 0; k < 3000 && cmd_ready_q !== 1'b1; k++) @(negedge ref_clk);
    if (k == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic cmd(input logic [1:0] t, input logic rw,
                     input logic [15:0] w);
    wait_ready();
    cmd_type = t;
    cmd_rw = rw;
    cmd_wdata = w;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    @(negedge ref_clk);
    wait_ready();
  endtask
  initial begin
    {ref_clk, cmd_valid, cmd_rw, use_as, dma_active} = '0;
    {gpio_mode, host_int_set, cmd_type, gpio_dir, gpio_drive} = '0;
    {cmd_wdata, got} = '0;
    {n_mismatch, checked, lo_run, lo_len, n_fall, n_cint} = '0;
    srst = 1'b1;
    repeat (5) @(negedge ref_clk);
    srst = 1'b0;
    // Word write and read back, idle then busy core bus
    for (int d = 0; d < 2; d++) begin
      dma_active = d[0];
      use_as = d[0];
      cmd(SEL_ADDR, 1'b0, 16'h0010);
      cmd(SEL_DATA_INC, 1'b0, 16'hbe00 + 16'(d));
      cmd(SEL_DATA_INC, 1'b0, 16'h1200 + 16'(d));
      len[d] = lo_len;
      chk(mem[8'h10], 16'hbe00 + 16'(d));
      cmd(SEL_ADDR, 1'b0, 16'h0010);
      cmd(SEL_DATA_INC, 1'b1, 16'h0000);
      chk(got, 16'hbe00 + 16'(d));
      cmd(SEL_DATA, 1'b1, 16'h0000);
      chk(got, 16'h1200 + 16'(d));
    end
    chk(16'(len[1] > len[0]), 16'h0001);
    $display("memory test done");
    c0 = n_fall;
    cmd(SEL_CTRL, 1'b0, 16'h0000);
    chk(16'(n_fall - c0), 16'h0000);
    cmd(SEL_CTRL, 1'b0, 16'h0002);
    chk(16'(n_fall - c0), 16'h0001);
    chk(16'(n_cint), 16'h0001);
    cmd(SEL_CTRL, 1'b1, 16'h0000);
    chk(got, 16'h0000);
    host_int_set = 1'b1;
    @(negedge ref_clk);
    host_int_set = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(bwhp_if_inst.host_interrupt_out_n, 16'h0000);
    cmd(SEL_CTRL, 1'b0, 16'h0004);
    repeat (4) @(negedge ref_clk);
    chk(bwhp_if_inst.host_interrupt_out_n, 16'h0001);
    $display("control test done");
    gpio_dir = 8'hf0;
    gpio_drive = 8'ha5;
    gpio_mode = 1'b1;
    // Bus settles in two cycles, then four sync stages and a core edge
    repeat (10) @(negedge ref_clk);
    chk(bwhp_if_inst.host_byte_bus, 16'h00af);
    chk(gpio_in_q, 16'h00af);
    chk(bwhp_if_inst.host_ready_out, 16'h0001);
    $display("pin mode test done");
    end_of_test();
  end
endmodule
`default_nettype wire
